//--- hdl/wbbr_pkg.sv
// package for the word bit/byte reversal unit
// assumes a single 40 MHz clock with synchronous reset
package wbbr_pkg;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int SLV_N = 64;
  localparam int SLV_W = 6;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESP_TARGET_US = 1000;
  localparam int RESP_TARGET_BYTES = 128;
  // longest time rounds down
  localparam int RESP_TARGET_CYC = (RESP_TARGET_US * 1000) / CLK_PERIOD_NS;
  localparam logic [SLV_N-1:0] MODE_RST = 64'h0000000000000000;
  localparam logic [15:0] LAT_RST = 16'h0000;
  typedef enum logic [1:0] {
    WBBR_MODE_NONE = 2'b00,
    WBBR_MODE_BIT = 2'b01,
    WBBR_MODE_BYTE = 2'b10,
    WBBR_MODE_BOTH = 2'b11
  } wbbr_mode_t;
endpackage : wbbr_pkg

//--- hdl/wbbr_fifo.sv
// parameterised word fifo with valid/ready on both sides
// assumes same clock and synchronous active-high reset as the caller
`timescale 1ns/10ps
`default_nettype none
module wbbr_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } wbbr_fifo_st_t;
  wbbr_fifo_st_t st;
  wbbr_fifo_st_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_wr;
  logic do_rd;

  // honest flags straight from the count
  assign o_in_ready = (st.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (st.cnt != '0);
  assign do_wr = i_in_valid && o_in_ready;
  assign do_rd = o_out_valid && i_out_ready;
  assign o_out_data = mem[st.rp];

  // pointer and count update
  always_comb begin
    next_st = st;
    if (do_wr) begin
      next_st.wp = st.wp + 1'b1;
    end
    if (do_rd) begin
      next_st.rp = st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // storage has no reset; only valid entries are ever read
  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[st.wp] <= i_in_data;
    end
  end

  // count never passes the depth, so no write lands on a full store
  chk_fifo_no_over: assert property (@(posedge i_clk) disable iff (i_rst)
    st.cnt <= (AW+1)'(DEPTH)) else $error("fifo count past depth");
endmodule : wbbr_fifo
`default_nettype wire

//--- hdl/wbbr_top.sv
// word bit/byte reversal unit between word memory and frame buffer
// assumes one clock; mode bits per slave come from configuration pins
// Notes on behaviour
// - bit mode mirrors all sixteen bits, both directions
// - no bit mode passes bits unchanged
// - numeric words pass unchanged with neither bit nor byte mode
// - slave response work about 1000 us per 128 bytes; the timer flags any wait over 40000 cycles, with no byte count
// - latency excludes line serialisation time
// - byte mode swaps word halves, both directions
// - both modes apply mirror and swap together
// - independent bit and byte setting per slave
`timescale 1ns/10ps
`default_nettype none
module wbbr_top (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic [wbbr_pkg::SLV_N-1:0] I_BIT_REV,
  input wire logic [wbbr_pkg::SLV_N-1:0] I_BYTE_REV,
  input wire logic I_IN_VALID,
  output logic O_IN_READY,
  input wire logic [wbbr_pkg::WORD_W-1:0] I_IN_DATA,
  input wire logic [wbbr_pkg::SLV_W-1:0] I_IN_SLAVE,
  output logic O_OUT_VALID,
  input wire logic I_OUT_READY,
  output logic [wbbr_pkg::WORD_W-1:0] O_OUT_DATA,
  input wire logic I_POLL_REQ,
  input wire logic I_RESP_START,
  output logic [15:0] O_RESP_CYC,
  output logic O_RESP_LATE
);
  // state of the unit outside the fifo in one record
  typedef struct packed {
    logic [wbbr_pkg::SLV_N-1:0] bit_sy1;
    logic [wbbr_pkg::SLV_N-1:0] bit_sy2;
    logic [wbbr_pkg::SLV_N-1:0] byte_sy1;
    logic [wbbr_pkg::SLV_N-1:0] byte_sy2;
    logic cvt_valid;
    logic [wbbr_pkg::WORD_W-1:0] cvt_data;
    logic out_valid;
    logic [wbbr_pkg::WORD_W-1:0] out_data;
    logic in_ready;
    logic [wbbr_pkg::FIFO_AW:0] fcnt;
    logic busy;
    logic [15:0] cnt;
    logic [15:0] resp_cyc;
    logic late;
  } wbbr_st_t;
  wbbr_st_t st;
  wbbr_st_t next_st;
  logic f_in_ready;
  logic f_out_valid;
  logic [wbbr_pkg::WORD_W-1:0] f_out_data;
  logic f_pop;

  // mirror bit order of one word
  function automatic logic [wbbr_pkg::WORD_W-1:0] wbbr_mirror(input logic [wbbr_pkg::WORD_W-1:0] w);
    logic [wbbr_pkg::WORD_W-1:0] r;
    r = '0;
    for (int k = 0; k < wbbr_pkg::WORD_W; k++) begin
      r[k] = w[wbbr_pkg::WORD_W-1-k];
    end
    return r;
  endfunction : wbbr_mirror

  // one conversion for both directions; the mode set decides
  function automatic logic [wbbr_pkg::WORD_W-1:0] wbbr_conv(input logic [wbbr_pkg::WORD_W-1:0] w,
                                                             input wbbr_pkg::wbbr_mode_t m);
    logic [wbbr_pkg::WORD_W-1:0] r;
    r = w;
    case (m)
      wbbr_pkg::WBBR_MODE_BIT: r = wbbr_mirror(w);
      wbbr_pkg::WBBR_MODE_BYTE: r = {w[7:0], w[15:8]};
      wbbr_pkg::WBBR_MODE_BOTH: r = wbbr_mirror({w[7:0], w[15:8]});
      default: r = w;
    endcase
    return r;
  endfunction : wbbr_conv

  // settings are pins from outside, so synchronise; configurer keeps them legal
  // are the configurer's to honour
  always_comb begin
    next_st = st;
    // two flops per pin; only the second one is ever decoded
    next_st.bit_sy1 = I_BIT_REV;
    next_st.bit_sy2 = st.bit_sy1;
    next_st.byte_sy1 = I_BYTE_REV;
    next_st.byte_sy2 = st.byte_sy1;
    // conversion stage, stalls when the fifo is full
    if (!st.cvt_valid || f_in_ready) begin
      next_st.cvt_valid = I_IN_VALID && st.in_ready;
      next_st.cvt_data = wbbr_conv(I_IN_DATA,
        wbbr_pkg::wbbr_mode_t'({st.byte_sy2[I_IN_SLAVE], st.bit_sy2[I_IN_SLAVE]}));
    end
    // shadow of the fifo fill, so ready can look one cycle ahead
    next_st.fcnt = st.fcnt + (wbbr_pkg::FIFO_AW+1)'(st.cvt_valid && f_in_ready) - (wbbr_pkg::FIFO_AW+1)'(f_pop);
    // ready is a register, so it must promise room at the next edge;
    // the fifo's own flag is a cycle stale and would let a word slip past
    next_st.in_ready = !next_st.cvt_valid || (next_st.fcnt != (wbbr_pkg::FIFO_AW+1)'(wbbr_pkg::FIFO_DEPTH));
    // output register fed from the fifo
    if (!st.out_valid || I_OUT_READY) begin
      next_st.out_valid = f_out_valid;
      next_st.out_data = f_out_data;
    end
    // poll to response timer, line time excluded by the strobes used
    if (I_POLL_REQ) begin
      next_st.busy = 1'b1;
      next_st.cnt = wbbr_pkg::LAT_RST;
    end else if (st.busy && I_RESP_START) begin
      next_st.busy = 1'b0;
      next_st.resp_cyc = st.cnt;
      next_st.late = (32'(st.cnt) > wbbr_pkg::RESP_TARGET_CYC);
    end else if (st.busy && st.cnt != 16'hFFFF) begin
      next_st.cnt = st.cnt + 16'h0001;
    end
  end

  // pop only when the output register can take the word
  assign f_pop = f_out_valid && (!st.out_valid || I_OUT_READY);

  // one register for the whole state; reset clears every field
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // eight words of slack between conversion and the frame buffer
  wbbr_fifo #(
    .WIDTH(wbbr_pkg::WORD_W),
    .DEPTH(wbbr_pkg::FIFO_DEPTH),
    .AW(wbbr_pkg::FIFO_AW)
  ) u_fifo (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_in_valid(st.cvt_valid),
    .o_in_ready(f_in_ready),
    .i_in_data(st.cvt_data),
    .o_out_valid(f_out_valid),
    .i_out_ready(f_pop),
    .o_out_data(f_out_data)
  );

  // outputs straight from the state register
  assign O_IN_READY = st.in_ready;
  assign O_OUT_VALID = st.out_valid;
  assign O_OUT_DATA = st.out_data;
  assign O_RESP_CYC = st.resp_cyc;
  assign O_RESP_LATE = st.late;

  // bit mode: top end of the mirror
  chk_bit_mirror: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (I_IN_VALID && st.in_ready && st.bit_sy2[I_IN_SLAVE] && !st.byte_sy2[I_IN_SLAVE])
    |=> st.cvt_data[15] == $past(I_IN_DATA[0])) else $error("bit mirror wrong");
  // low end as well, so a half mirror cannot pass
  chk_bit_low: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (I_IN_VALID && st.in_ready && st.bit_sy2[I_IN_SLAVE] && !st.byte_sy2[I_IN_SLAVE])
    |=> st.cvt_data[0] == $past(I_IN_DATA[15])) else $error("bit mirror low end wrong");
  // plain words travel untouched, numeric values included
  chk_pass_through: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (I_IN_VALID && st.in_ready && !st.bit_sy2[I_IN_SLAVE] && !st.byte_sy2[I_IN_SLAVE])
    |=> st.cvt_data == $past(I_IN_DATA)) else $error("plain word altered");
  // byte mode: halves exchanged
  chk_byte_swap: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (I_IN_VALID && st.in_ready && !st.bit_sy2[I_IN_SLAVE] && st.byte_sy2[I_IN_SLAVE])
    |=> st.cvt_data == {$past(I_IN_DATA[7:0]), $past(I_IN_DATA[15:8])}) else $error("byte swap wrong");
  // both modes: each byte ends up mirrored in place
  chk_both_modes: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (I_IN_VALID && st.in_ready && st.bit_sy2[I_IN_SLAVE] && st.byte_sy2[I_IN_SLAVE])
    |=> st.cvt_data[0] == $past(I_IN_DATA[7])) else $error("combined mode wrong");
  // other end of the combined mapping
  chk_both_high: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (I_IN_VALID && st.in_ready && st.bit_sy2[I_IN_SLAVE] && st.byte_sy2[I_IN_SLAVE])
    |=> st.cvt_data[15] == $past(I_IN_DATA[8])) else $error("combined mode high end wrong");

  // a word taken shows in the stage one cycle later
  chk_one_cycle: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (I_IN_VALID && st.in_ready)
    |=> st.cvt_valid) else $error("word not taken");
  // ready high means the stage really moves on this edge
  chk_no_lost_word: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (I_IN_VALID && st.in_ready)
    |-> (!st.cvt_valid || f_in_ready)) else $error("word taken while stage blocked");
  // output word stands until the sink takes it
  chk_out_hold: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (O_OUT_VALID && !I_OUT_READY)
    |=> (O_OUT_VALID && $stable(O_OUT_DATA))) else $error("output word dropped");
  // per-slave selection really reaches the converter
  chk_mode_select: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (I_IN_VALID && st.in_ready && st.bit_sy2[I_IN_SLAVE] != st.byte_sy2[I_IN_SLAVE] && I_IN_DATA == 16'h0001)
    |=> st.cvt_data != 16'h0001) else $error("slave setting ignored");

  // response timer: no late flag for an instant answer
  chk_late_flag: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (st.busy && I_RESP_START && !I_POLL_REQ && st.cnt == 16'h0000)
    |=> !O_RESP_LATE) else $error("late set early");
  // late flag raised once the target is passed
  chk_late_set: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (st.busy && I_RESP_START && !I_POLL_REQ && 32'(st.cnt) > wbbr_pkg::RESP_TARGET_CYC)
    |=> O_RESP_LATE) else $error("late flag missing");
  // timer stops at the response start
  chk_busy_clear: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (st.busy && I_RESP_START && !I_POLL_REQ)
    |=> !st.busy) else $error("timer still running");
  // count covers only the work between poll and response start
  chk_resp_count: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_POLL_REQ ##1 (!I_POLL_REQ && !I_RESP_START) [*3] ##1 (I_RESP_START && !I_POLL_REQ)
    |=> O_RESP_CYC == 16'h0003) else $error("response count wrong");
  // reported count moves only at a response start
  chk_resp_hold: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !(st.busy && I_RESP_START && !I_POLL_REQ)
    |=> $stable(O_RESP_CYC)) else $error("response count moved");
endmodule : wbbr_top
`default_nettype wire

//--- test/wbbr_sink.sv
// far-side frame buffer model taking converted words
// assumes the unit's clock; ready moves 1 ns after each rising edge
`timescale 1ns/10ps
`default_nettype none
module wbbr_sink (
  input wire logic i_clk,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire logic [wbbr_pkg::WORD_W-1:0] i_data,
  output logic o_ready
);
  logic [wbbr_pkg::WORD_W-1:0] got [$];
  initial o_ready = 1'b0;
  // ready follows stall, so back-pressure is real
  always @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      got.push_back(i_data);
    end
    #1 o_ready <= !i_stall;
  end
endmodule : wbbr_sink
`default_nettype wire

//--- test/tb_word_bit_byte_reversal.sv
// self-checking bench for the word reversal unit
// assumes wbbr_top and the sink model; inputs move 1 ns after the edge
`timescale 1ns/10ps
`default_nettype none
module tb_word_bit_byte_reversal;
  logic I_CLK = 1'b0;
  logic I_SYS_RST = 1'b1;
  logic [63:0] I_BIT_REV = 64'h0;
  logic [63:0] I_BYTE_REV = 64'h0;
  logic I_IN_VALID = 1'b0;
  logic [15:0] I_IN_DATA = 16'h0;
  logic [5:0] I_IN_SLAVE = 6'h0;
  logic I_POLL_REQ = 1'b0;
  logic I_RESP_START = 1'b0;
  logic stall = 1'b0;
  logic O_IN_READY, O_OUT_VALID, I_OUT_READY, O_RESP_LATE;
  logic [15:0] O_OUT_DATA, O_RESP_CYC;
  logic [15:0] exp_q [$];
  int error_cnt = 0;
  int samples_checked = 0;
  always #12.5 I_CLK = ~I_CLK;
  wbbr_top DUT (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_BIT_REV(I_BIT_REV), .I_BYTE_REV(I_BYTE_REV),
    .I_IN_VALID(I_IN_VALID), .O_IN_READY(O_IN_READY), .I_IN_DATA(I_IN_DATA), .I_IN_SLAVE(I_IN_SLAVE),
    .O_OUT_VALID(O_OUT_VALID), .I_OUT_READY(I_OUT_READY), .O_OUT_DATA(O_OUT_DATA),
    .I_POLL_REQ(I_POLL_REQ), .I_RESP_START(I_RESP_START), .O_RESP_CYC(O_RESP_CYC), .O_RESP_LATE(O_RESP_LATE));
  wbbr_sink SINK (.i_clk(I_CLK), .i_stall(stall), .i_valid(O_OUT_VALID), .i_data(O_OUT_DATA), .o_ready(I_OUT_READY));
  // reference conversion: swap halves, then mirror
  function automatic logic [15:0] conv(logic [15:0] w, logic bit_on, logic byte_on);
    logic [15:0] r;
    r = byte_on ? {w[7:0], w[15:8]} : w;
    return bit_on ? {<<{r}} : r;
  endfunction : conv
  task automatic check(string what, logic [15:0] exp, logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // valid stays high on return so back-to-back words need no gap
  task automatic send(logic [5:0] slv, logic [15:0] w);
    int k;
    I_IN_VALID = 1'b1;
    I_IN_SLAVE = slv;
    I_IN_DATA = w;
    exp_q.push_back(conv(w, I_BIT_REV[slv], I_BYTE_REV[slv]));
    for (k = 0; k < 200 && O_IN_READY !== 1'b1; k++) begin
      @(posedge I_CLK);
      #1;
    end
    @(posedge I_CLK);
    #1;
  endtask : send
  // bounded wait for the sink, then compare in order
  task automatic drain(int n);
    int k;
    for (k = 0; k < 300 && SINK.got.size() < n; k++) begin
      @(posedge I_CLK);
      #1;
    end
    check("word count", 16'(n), 16'(SINK.got.size()));
    while (exp_q.size() > 0 && SINK.got.size() > 0) check("out word", exp_q.pop_front(), SINK.got.pop_front());
    exp_q.delete();
    SINK.got.delete();
  endtask : drain
  task automatic test_modes();
    int s;
    I_BIT_REV = 64'h800000000000000A; // bit mode only on discrete slaves
    I_BYTE_REV = 64'h000000000000000C; // slave 0 keeps both off
    repeat (3) @(posedge I_CLK);
    #1;
    for (s = 0; s < 5; s++) begin
      send((s == 4) ? 6'h3F : 6'(s), 16'h0001);
      send((s == 4) ? 6'h3F : 6'(s), 16'h12C4);
    end
    I_IN_VALID = 1'b0;
    drain(10);
    $display("test_modes done");
  endtask : test_modes
  // sink stalls for 30 cycles so the unit refuses, then everything drains in order
  task automatic test_stall();
    int k;
    int acc;
    logic rdy;
    acc = 0;
    stall = 1'b1;
    I_IN_VALID = 1'b1;
    I_IN_SLAVE = 6'h3;
    for (k = 0; k < 30; k++) begin
      I_IN_DATA = 16'hA000 + 16'(acc);
      rdy = O_IN_READY;
      @(posedge I_CLK);
      #1;
      if (rdy === 1'b1) begin
        exp_q.push_back(conv(16'hA000 + 16'(acc), 1'b1, 1'b1));
        acc++;
      end
    end
    check("in ready when full", 16'h0, {15'h0, O_IN_READY});
    check("words held", 16'h1, {15'h0, acc >= wbbr_pkg::FIFO_DEPTH});
    I_IN_VALID = 1'b0;
    stall = 1'b0;
    drain(acc);
    $display("test_stall done");
  endtask : test_stall
  task automatic test_resp(int n, logic late);
    I_POLL_REQ = 1'b1;
    @(posedge I_CLK);
    #1;
    I_POLL_REQ = 1'b0;
    repeat (n - 1) @(posedge I_CLK);
    #1;
    I_RESP_START = 1'b1;
    @(posedge I_CLK);
    #1;
    I_RESP_START = 1'b0;
    @(posedge I_CLK);
    #1;
    check("response cycles", 16'(n - 1), O_RESP_CYC);
    check("response late", {15'h0, late}, {15'h0, O_RESP_LATE});
    $display("test_resp done");
  endtask : test_resp
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  // main sequence: reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge I_CLK);
    #1;
    I_SYS_RST = 1'b0;
    check("out valid after reset", 16'h0, {15'h0, O_OUT_VALID});
    @(posedge I_CLK);
    #1;
    check("in ready after reset", 16'h1, {15'h0, O_IN_READY});
    test_modes();
    test_stall();
    test_resp(4, 1'b0);
    test_resp(100, 1'b0);
    test_resp(40001, 1'b0);
    test_resp(40002, 1'b1);
    finish_test();
  end
  // watchdog: whole run is about 80200 cycles
  initial begin
    repeat (90000) @(posedge I_CLK);
    error_cnt++;
    finish_test();
  end
endmodule : tb_word_bit_byte_reversal
`default_nettype wire
